// ---- pkg/tbdpwm_consts.vh ----
// Register offsets, field positions and reset values of the dual modulator
`ifndef TBDPWM_CONSTS_VH
`define TBDPWM_CONSTS_VH

`define TBDPWM_OFF_PERIOD    8'h00
`define TBDPWM_OFF_TCTRL     8'h04
`define TBDPWM_OFF_COUNT     8'h08
`define TBDPWM_OFF_FLAGS     8'h0C
`define TBDPWM_OFF_CTRL1     8'h10
`define TBDPWM_OFF_DHIGH1    8'h14
`define TBDPWM_OFF_DLOW1     8'h18
`define TBDPWM_OFF_CTRL2     8'h1C
`define TBDPWM_OFF_DHIGH2    8'h20
`define TBDPWM_OFF_DLOW2     8'h24
`define TBDPWM_OFF_PINDIR    8'h28
`define TBDPWM_OFF_PORTLAT   8'h2C

`define TBDPWM_RST_PERIOD    8'hFF
`define TBDPWM_RST_BYTE      8'h00
`define TBDPWM_RST_PINDIR    2'h3

`define TBDPWM_TC_RUN        2
`define TBDPWM_TC_PS_HI      1
`define TBDPWM_TC_PS_LO      0
`define TBDPWM_TC_POST_HI    6
`define TBDPWM_TC_POST_LO    3

`define TBDPWM_CC_EN         7
`define TBDPWM_CC_OE         6
`define TBDPWM_CC_OUT        5
`define TBDPWM_CC_POL        4

`define TBDPWM_DL_HI         7
`define TBDPWM_DL_LO         6

`define TBDPWM_PS_1          2'h0
`define TBDPWM_PS_4          2'h1
`define TBDPWM_PS_16         2'h2
`define TBDPWM_PS_64         2'h3
`define TBDPWM_DIV_1         6'h00
`define TBDPWM_DIV_4         6'h03
`define TBDPWM_DIV_16        6'h0F
`define TBDPWM_DIV_64        6'h3F

`define TBDPWM_HTRANS_NONSEQ 2'h2
`define TBDPWM_HSIZE_WORD    3'h2
`define TBDPWM_ADDR_MSB      7

`endif

// ---- logic/tbdpwm_top.v ----
// Timer based dual pulse width modulator with AHB-Lite register slave
//
// Notes on behaviour
// - Outputs have up to ten bit duty resolution
// - Shared period, independent duty per channel
// - Outputs go active when base counter clears, unless duty is zero
// - Output inactive when extended counter equals duty
// - Time base: base counter plus two prescaled bits
// - Duty high byte at or above period limit: never cleared
// - Duty double buffered, latched on period match
// - Polarity bit makes active level low
// - Period is (limit+1) times four times prescale
// - After match: clear, activate unless zero, latch
// - Postscaler does not affect the modulator
// - Duty high holds MSBs, low bits 7:6
// - Duty writes accepted any time, no glitch
// - Prescale one: extra bits count system clock
// - Resolution log2 of 4(limit+1) bits
// - Pulse wider than period: pin unchanged
// - Sleep freezes counter, state and outputs
// - Output frequency scales with system clock
// - Reset restores defaults, pins to input
// - Output muxed with port latch via output enable and pin direction
`include "tbdpwm_consts.vh"

module tbdpwm_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        sleep_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  output reg  [1:0]  pwm_pin_o,
  output reg  [1:0]  pwm_pin_oe_o,
  output reg  [1:0]  pwm_level_o
);

  // Software visible registers plus internal prescaler, postscaler and duty buffer state
  reg  [7:0]  period_limit_reg;
  reg  [6:0]  base_timer_control_reg;
  reg  [7:0]  base_counter_reg;
  reg  [1:0]  prescale_cnt_reg;
  reg  [5:0]  prediv_cnt_reg;
  reg         base_overflow_flag_reg;
  reg  [3:0]  post_cnt_reg;
  reg         post_flag_reg;
  reg  [1:0]  en_reg;
  reg  [1:0]  oe_reg;
  reg  [1:0]  pol_reg;
  reg  [7:0]  duty_high_reg  [0:1];
  reg  [1:0]  duty_low_reg   [0:1];
  reg  [9:0]  duty_buf_reg   [0:1];
  reg  [1:0]  pwm_raw_reg;
  reg  [1:0]  pin_direction_reg;
  reg  [1:0]  port_latch_reg;

  // Bus data phase state
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;

  wire        run      = base_timer_control_reg[`TBDPWM_TC_RUN];
  wire [1:0]  ps_sel   = base_timer_control_reg[`TBDPWM_TC_PS_HI:`TBDPWM_TC_PS_LO];
  wire [3:0]  post_sel = base_timer_control_reg[`TBDPWM_TC_POST_HI:`TBDPWM_TC_POST_LO];
  wire        active   = run & ~sleep_i;

  reg  [5:0]  div_lim;
  always @* begin
    case (ps_sel)
      `TBDPWM_PS_1:  div_lim = `TBDPWM_DIV_1;
      `TBDPWM_PS_4:  div_lim = `TBDPWM_DIV_4;
      `TBDPWM_PS_16: div_lim = `TBDPWM_DIV_16;
      default:       div_lim = `TBDPWM_DIV_64;
    endcase
  end

  // One pulse per prescaled system clock
  wire        tick      = active & (prediv_cnt_reg >= div_lim);
  wire        cnt_step  = tick & (prescale_cnt_reg == 2'h3);
  wire        match     = base_counter_reg == period_limit_reg;
  wire        restart   = cnt_step & match;
  wire [9:0]  ext_count = {base_counter_reg, prescale_cnt_reg};
  // Next time base value, so the clear lands as the count reaches the duty
  wire [9:0]  ext_next  = ext_count + 10'h001;

  // Bus address phase
  wire        addr_ok   = hsel_i & hready_i & htrans_i[1];
  wire [7:0]  a_byte    = haddr_i[`TBDPWM_ADDR_MSB:0];
  wire        wr_now    = wr_pend_reg;
  wire [7:0]  wdat      = hwdata_i[7:0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= `TBDPWM_RST_BYTE;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= {32{1'b0}};
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend_reg <= addr_ok & hwrite_i;
      if (addr_ok)
        wr_addr_reg <= a_byte;
      if (addr_ok & ~hwrite_i) begin
        hrdata_o <= {32{1'b0}};
        case (a_byte)
          `TBDPWM_OFF_PERIOD: hrdata_o[7:0] <= period_limit_reg;
          `TBDPWM_OFF_TCTRL:  hrdata_o[6:0] <= base_timer_control_reg;
          `TBDPWM_OFF_COUNT:  hrdata_o[7:0] <= base_counter_reg;
          `TBDPWM_OFF_FLAGS:  hrdata_o[1:0] <= {post_flag_reg, base_overflow_flag_reg};
          `TBDPWM_OFF_CTRL1:  hrdata_o[7:4] <= {en_reg[0], oe_reg[0], pwm_raw_reg[0],
                                                pol_reg[0]};
          `TBDPWM_OFF_DHIGH1: hrdata_o[7:0] <= duty_high_reg[0];
          `TBDPWM_OFF_DLOW1:  hrdata_o[7:6] <= duty_low_reg[0];
          `TBDPWM_OFF_CTRL2:  hrdata_o[7:4] <= {en_reg[1], oe_reg[1], pwm_raw_reg[1],
                                                pol_reg[1]};
          `TBDPWM_OFF_DHIGH2: hrdata_o[7:0] <= duty_high_reg[1];
          `TBDPWM_OFF_DLOW2:  hrdata_o[7:6] <= duty_low_reg[1];
          `TBDPWM_OFF_PINDIR: hrdata_o[1:0] <= pin_direction_reg;
          `TBDPWM_OFF_PORTLAT: hrdata_o[1:0] <= port_latch_reg;
          default:            hrdata_o <= {32{1'b0}};
        endcase
      end
    end
  end

  // Timer, prescaler and flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      period_limit_reg       <= `TBDPWM_RST_PERIOD;
      base_timer_control_reg <= 7'h00;
      base_counter_reg       <= `TBDPWM_RST_BYTE;
      prescale_cnt_reg       <= 2'h0;
      prediv_cnt_reg         <= 6'h00;
      base_overflow_flag_reg <= 1'b0;
      post_cnt_reg           <= 4'h0;
      post_flag_reg          <= 1'b0;
      pin_direction_reg      <= `TBDPWM_RST_PINDIR;
      port_latch_reg         <= 2'h0;
    end else begin
      if (active)
        prediv_cnt_reg <= tick ? 6'h00 : prediv_cnt_reg + 6'h01;
      if (tick)
        prescale_cnt_reg <= prescale_cnt_reg + 2'h1;
      if (cnt_step)
        base_counter_reg <= match ? `TBDPWM_RST_BYTE
                                  : base_counter_reg + 8'h01;
      // Postscaler only feeds its own flag
      if (restart)
        post_cnt_reg <= (post_cnt_reg == post_sel) ? 4'h0
                                                   : post_cnt_reg + 4'h1;
      if (wr_now) begin
        case (wr_addr_reg)
          `TBDPWM_OFF_PERIOD:  period_limit_reg <= wdat;
          `TBDPWM_OFF_TCTRL:   base_timer_control_reg <= wdat[6:0];
          `TBDPWM_OFF_COUNT:   base_counter_reg <= wdat;
          `TBDPWM_OFF_PINDIR:  pin_direction_reg <= wdat[1:0];
          `TBDPWM_OFF_PORTLAT: port_latch_reg <= wdat[1:0];
          default:             ;
        endcase
      end
      // Write one to clear; a new event wins
      if (wr_now && wr_addr_reg == `TBDPWM_OFF_FLAGS) begin
        if (wdat[0]) base_overflow_flag_reg <= 1'b0;
        if (wdat[1]) post_flag_reg <= 1'b0;
      end
      if (restart)
        base_overflow_flag_reg <= 1'b1;
      if (restart && post_cnt_reg == post_sel)
        post_flag_reg <= 1'b1;
    end
  end

  // Per channel duty, compare and pin mux
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire [7:0] ctrl_off = (ch == 0) ? `TBDPWM_OFF_CTRL1  : `TBDPWM_OFF_CTRL2;
      wire [7:0] dh_off   = (ch == 0) ? `TBDPWM_OFF_DHIGH1 : `TBDPWM_OFF_DHIGH2;
      wire [7:0] dl_off   = (ch == 0) ? `TBDPWM_OFF_DLOW1  : `TBDPWM_OFF_DLOW2;
      wire [9:0] new_duty = {duty_high_reg[ch], duty_low_reg[ch]};
      // Duty whose high byte is at or above the period limit never reaches the clear compare
      wire       never_clr = duty_buf_reg[ch][9:2] >= period_limit_reg;
      wire       cmp_hit   = ext_next == duty_buf_reg[ch];
      wire       drive     = oe_reg[ch] & ~pin_direction_reg[ch];
      wire       lvl       = pwm_raw_reg[ch] ^ pol_reg[ch];

      always @(posedge clk_i) begin
        if (rst_i) begin
          en_reg[ch]        <= 1'b0;
          oe_reg[ch]        <= 1'b0;
          pol_reg[ch]       <= 1'b0;
          duty_high_reg[ch] <= `TBDPWM_RST_BYTE;
          duty_low_reg[ch]  <= 2'h0;
          duty_buf_reg[ch]  <= 10'h000;
          pwm_raw_reg[ch]   <= 1'b0;
          pwm_pin_o[ch]     <= 1'b0;
          pwm_pin_oe_o[ch]  <= 1'b0;
          pwm_level_o[ch]   <= 1'b0;
        end else begin
          // Duty writes land in the shadow copy only; control bits take effect at once
          if (wr_now && wr_addr_reg == ctrl_off) begin
            en_reg[ch]  <= wdat[`TBDPWM_CC_EN];
            oe_reg[ch]  <= wdat[`TBDPWM_CC_OE];
            pol_reg[ch] <= wdat[`TBDPWM_CC_POL];
          end
          if (wr_now && wr_addr_reg == dh_off)
            duty_high_reg[ch] <= wdat;
          if (wr_now && wr_addr_reg == dl_off)
            duty_low_reg[ch] <= wdat[`TBDPWM_DL_HI:`TBDPWM_DL_LO];
          if (restart)
            duty_buf_reg[ch] <= new_duty;
          if (!en_reg[ch])
            pwm_raw_reg[ch] <= 1'b0;
          else if (restart)
            pwm_raw_reg[ch] <= (new_duty != 10'h000);
          else if (tick && cmp_hit && !never_clr)
            pwm_raw_reg[ch] <= 1'b0;
          if (!sleep_i) begin
            pwm_level_o[ch]  <= lvl;
            pwm_pin_o[ch]    <= drive ? lvl : port_latch_reg[ch];
            pwm_pin_oe_o[ch] <= ~pin_direction_reg[ch];
          end
        end
      end
    end
  endgenerate

endmodule

// ---- test/tbdpwm_props.sv ----
// Port checker for the dual modulator
`include "tbdpwm_consts.vh"
module tbdpwm_props (
  input wire        clk_i,
  input wire        rst_i,
  input wire        sleep_i,
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire [1:0]  pwm_pin_o,
  input wire [1:0]  pwm_pin_oe_o,
  input wire [1:0]  pwm_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd_req = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  a_ready_high: assert property (hreadyout_o) else $error("slave stalled");
  a_resp_okay: assert property (!hresp_o) else $error("error response");
  a_sleep_hold: assert property (sleep_i [*5] |-> $stable(pwm_level_o)
    && $stable(pwm_pin_o)) else $error("output moved in sleep");
  a_reset_pins: assert property (disable iff (1'b0) rst_i |=> pwm_pin_oe_o == 2'h0
    && pwm_pin_o == 2'h0 && hrdata_o == 32'h0000_0000) else $error("reset state");
  a_unmapped_zero: assert property (rd_req && haddr_i[31:8] == 24'h00_0000
    && haddr_i[7:0] > 8'h2C |=> hrdata_o == 32'h0000_0000) else $error("unmapped data");
  a_dlow_bits: assert property (rd_req && haddr_i == {24'h00_0000, `TBDPWM_OFF_DLOW1}
    |=> hrdata_o[5:0] == 6'h00) else $error("duty low spare bits");
  a_rdata_byte: assert property (hrdata_o[31:8] == 24'h00_0000) else $error("wide data");
  a_oe_cause: assert property (!$past(hsel_i) && !$past(hsel_i, 2)
    && !$past(hsel_i, 3) |-> $stable(pwm_pin_oe_o)) else $error("drive changed alone");
  c_read: cover property (rd_req);
  c_sleep: cover property (sleep_i [*5]);
  c_rise: cover property ($rose(pwm_level_o[0]));
endmodule
bind tbdpwm_top tbdpwm_props i_tbdpwm_props (.clk_i, .rst_i, .sleep_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .pwm_pin_o,
  .pwm_pin_oe_o, .pwm_level_o);

// ---- test/tbdpwm_pin_model.sv ----
// Port pads beyond the modulator, with weak pull-ups
module tbdpwm_pin_model (
  input  wire [1:0] pin_i,
  input  wire [1:0] oe_i,
  output wire [1:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_o = (pin_i & oe_i) | ~oe_i; // Undriven pad pulled high
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the dual modulator
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `include "tbdpwm_consts.vh"
  localparam int TC[5] = '{8'hC0, 8'hC0, 8'hC0, 8'hD0, 8'h40};
  localparam int TD[5] = '{0, 12, 15, 5, 5};
  localparam int TA[5] = '{1, 1, 1, 0, 1};
  localparam int TH[5] = '{0, 16, 16, 5, 0};
  localparam int TR[5] = '{0, 0, 0, 2, 0};
  logic        clk_i = 1'b0, rst_i = 1'b1, sleep_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, exp_q[$], obs_q[$];
  wire  [31:0] hrdata_o;
  wire         hreadyout_o, hresp_o;
  wire  [1:0]  pwm_pin_o, pwm_pin_oe_o, pwm_level_o, pad;
  int          bad_count = 0, n_checks = 0;
  event        obs_ev;
  always #2 clk_i = ~clk_i;
  tbdpwm_top i_tbdpwm_top (.clk_i, .rst_i, .sleep_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(`TBDPWM_HSIZE_WORD), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .pwm_pin_o, .pwm_pin_oe_o, .pwm_level_o);
  tbdpwm_pin_model i_tbdpwm_pin_model (.pin_i(pwm_pin_o), .oe_i(pwm_pin_oe_o), .pad_o(pad));
  always @(obs_ev) begin
    while (obs_q.size() > 0) begin
      n_checks++;
      if (obs_q[0] !== exp_q[0]) begin
        bad_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, obs_q[0], exp_q[0]);
      end
      void'(obs_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  task automatic note(input logic [31:0] e, input logic [31:0] o);
    exp_q.push_back(e);
    obs_q.push_back(o);
    ->obs_ev;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    htrans_i <= `TBDPWM_HTRANS_NONSEQ;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    note(e, q);
  endtask
  task automatic duty(input int ch, input int d);
    wr(ch ? `TBDPWM_OFF_DHIGH2 : `TBDPWM_OFF_DHIGH1, d >> 2);
    wr(ch ? `TBDPWM_OFF_DLOW2 : `TBDPWM_OFF_DLOW1, ((d & 3) << 6) | $urandom_range(63, 0));
  endtask
  // Window of two whole periods: active count and entries into active level
  task automatic wave(input int ch, input logic act, input int hi, input int per, input int nr);
    int h, r;
    logic p;
    h = 0;
    r = 0;
    p = pwm_level_o[ch];
    repeat (2 * per) begin
      @(posedge clk_i);
      if (pwm_level_o[ch] === act) h++;
      if (pwm_level_o[ch] === act && p !== act) r++;
      p = pwm_level_o[ch];
    end
    note(2 * hi, h);
    note(nr, r);
  endtask
  task automatic stop_test;
    @(posedge clk_i);
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    logic [31:0] t;
    int ps, d1, d2;
    void'($urandom(32'hc3a9));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(8'h30, 32'h0000_00FF);
    rd(8'h30, 32'h0000_0000);
    rd(`TBDPWM_OFF_PERIOD, 32'h0000_00FF);
    rd(`TBDPWM_OFF_PINDIR, 32'h0000_0003);
    rd(`TBDPWM_OFF_CTRL1, 32'h0000_0000);
    $display("reset test done");
    wr(`TBDPWM_OFF_PINDIR, 32'h0000_0003);
    wr(`TBDPWM_OFF_CTRL1, 32'h0000_0000);
    wr(`TBDPWM_OFF_CTRL2, 32'h0000_0000);
    wr(`TBDPWM_OFF_PERIOD, 32'h0000_0003);
    duty(0, 0);
    duty(1, 0);
    wr(`TBDPWM_OFF_FLAGS, 32'h0000_0001);
    wr(`TBDPWM_OFF_TCTRL, 32'h0000_0004);
    t = 32'h0000_0000;
    for (int i = 0; i < 100 && t[0] !== 1'b1; i++) bus(1'b0, `TBDPWM_OFF_FLAGS, 0, t);
    note(1, t[0]);
    wr(`TBDPWM_OFF_PINDIR, 32'h0000_0000);
    wr(`TBDPWM_OFF_CTRL1, 32'h0000_00C0);
    wr(`TBDPWM_OFF_CTRL2, 32'h0000_00C0);
    note(3, pwm_pin_oe_o);
    $display("setup test done");
    for (int k = 0; k < 4; k++) begin
      ps = 1 << (2 * k);
      d1 = $urandom_range(11, 1);
      d2 = $urandom_range(11, 1);
      duty(0, d1);
      duty(1, d2);
      rd(`TBDPWM_OFF_DLOW1, (d1 & 3) << 6);
      wr(`TBDPWM_OFF_TCTRL, 4 | k | ($urandom_range(15, 0) << 3));
      repeat (32 * ps) @(posedge clk_i);
      wave(0, 1'b1, d1 * ps, 16 * ps, 2);
      wave(1, 1'b1, d2 * ps, 16 * ps, 2);
    end
    $display("prescale test done");
    wr(`TBDPWM_OFF_TCTRL, 32'h0000_0004);
    for (int j = 0; j < 5; j++) begin
      wr(`TBDPWM_OFF_CTRL1, TC[j]);
      duty(0, TD[j]);
      repeat (40) @(posedge clk_i);
      wave(0, TA[j], TH[j], 16, TR[j]);
    end
    $display("duty table test done");
    wr(`TBDPWM_OFF_CTRL1, 32'h0000_00C0);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    sleep_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    wave(0, 1'b1, 5, 16, 2);
    wr(`TBDPWM_OFF_PORTLAT, 32'h0000_0001);
    wr(`TBDPWM_OFF_CTRL1, 32'h0000_0080);
    repeat (4) @(posedge clk_i);
    note(1, pad[0]);
    wr(`TBDPWM_OFF_PINDIR, 32'h0000_0003);
    repeat (4) @(posedge clk_i);
    note(3, {pwm_pin_oe_o, pad});
    $display("pin test done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TBDPWM_OFF_PERIOD, 32'h0000_00FF);
    rd(`TBDPWM_OFF_CTRL1, 32'h0000_0000);
    $display("second reset test done");
    stop_test();
  end
endmodule
